/* flag_arith_decoder.v */
`timescale 1ns/1ps
`include "flag_arith_consts.vh"

module flag_arith_decoder (
	// clock and reset
	input  wire       clk,
	input  wire       rst,
	// instruction bytes from the prefetch queue
	input  wire       instr_valid,
	input  wire [7:0] opcode,
	input  wire [7:0] modrm,
	// decode result to the datapath
	output reg        dec_valid_q,
	output reg        dec_known_q,
	output reg  [4:0] op_code_q,
	output reg  [3:0] clocks_q,
	output reg        has_modrm_q,
	output reg        mem_operand_q,
	output reg        word_op_q,
	output reg        reg_is_dest_q,
	output reg        sign_extend_q,
	output reg        acc_imm_q,
	output reg  [1:0] imm_bytes_q,
	output reg  [2:0] reg_num_q,
	output reg  [2:0] rm_num_q
);

	// ****************************************
	// combinational decode
	// ****************************************
	reg       known_d;
	reg [4:0] op_d;
	reg [3:0] clk_d;
	reg       modrm_d;
	reg       word_d;
	reg       dest_d;
	reg       sext_d;
	reg       acc_d;
	reg [1:0] imm_d;
	reg [2:0] reg_d;

	wire [2:0] sub   = modrm[5:3];
	wire       is_mem = (modrm[7:6] != `MOD_REG);

	// register-form cost or memory-form cost picked by mod
	function [3:0] cost;
		input       mem;
		input [3:0] rcost;
		input [3:0] mcost;
		begin
			cost = mem ? mcost : rcost;
		end
	endfunction

	always @* begin
		known_d = 1'b1;
		op_d    = `OP_NONE;
		clk_d   = 4'h0;
		modrm_d = 1'b0;
		word_d  = opcode[0];
		dest_d  = 1'b0;
		sext_d  = 1'b0;
		acc_d   = 1'b0;
		imm_d   = 2'h0;
		reg_d   = modrm[5:3];
		if (opcode == `PAT_FLAGS_TO_HA) begin
			op_d   = `OP_FLAGS_TO_HA;
			clk_d  = `CLK_2;
			word_d = 1'b0;
		end else if (opcode == `PAT_HA_TO_FLAGS) begin
			op_d   = `OP_HA_TO_FLAGS;
			clk_d  = `CLK_2;
			word_d = 1'b0;
		end else if (opcode == `PAT_AAA) begin
			op_d   = `OP_AAA;
			clk_d  = `CLK_3;
			word_d = 1'b0;
		end else if (opcode[7:6] == 2'b00 && opcode[2] == 1'b0
				&& opcode[5:3] != 3'b111 && opcode[5:3] != 3'b001
				&& opcode[5:3] != 3'b100 && opcode[5:3] != 3'b110) begin
			// two-operand register/memory forms, opcode 00xxx0dw
			modrm_d = 1'b1;
			dest_d  = opcode[1];
			case (opcode[5:3])
				3'b000: begin
					op_d  = `OP_ADD;
					clk_d = cost(is_mem, `CLK_2, `CLK_7);
				end
				3'b010: begin
					op_d  = `OP_ADC;
					clk_d = cost(is_mem, `CLK_2, `CLK_7);
				end
				3'b101: begin
					op_d  = `OP_SUB;
					clk_d = cost(is_mem, `CLK_2, `CLK_7);
				end
				3'b011: begin
					op_d  = `OP_SUB_BORROW;
					clk_d = cost(is_mem, `CLK_2, `CLK_7);
				end
				default: known_d = 1'b0;
			endcase
		end else if (opcode[7:6] == 2'b00 && opcode[2:1] == 2'b10) begin
			// accumulator-immediate forms, opcode 00xxx10w
			acc_d = 1'b1;
			clk_d = `CLK_3;
			imm_d = opcode[0] ? 2'h2 : 2'h1;
			case (opcode[5:3])
				3'b000:  op_d = `OP_ADD;
				3'b010:  op_d = `OP_ADC;
				3'b101:  op_d = `OP_SUB;
				3'b011:  op_d = `OP_SUB_BORROW;
				3'b111:  op_d = `OP_COMPARE;
				default: known_d = 1'b0;
			endcase
		end else if (opcode[7:1] == `PAT_COMPARE_RM_HI) begin
			op_d    = `OP_COMPARE;
			modrm_d = 1'b1;
			dest_d  = 1'b1;
			clk_d   = cost(is_mem, `CLK_2, `CLK_6);
		end else if (opcode[7:1] == `PAT_COMPARE_REG_HI) begin
			op_d    = `OP_COMPARE;
			modrm_d = 1'b1;
			clk_d   = cost(is_mem, `CLK_2, `CLK_7);
		end else if (opcode[7:2] == `PAT_GRP1_HI) begin
			// immediate group, sub-field picks the operation
			modrm_d = 1'b1;
			sext_d  = opcode[1];
			// second data byte only when s,w is 01
			imm_d   = (opcode[1:0] == 2'b01) ? 2'h2 : 2'h1;
			case (sub)
				`SUB_ADD: begin
					op_d  = `OP_ADD;
					clk_d = cost(is_mem, `CLK_3, `CLK_7);
				end
				`SUB_ADC: begin
					op_d  = `OP_ADC;
					clk_d = cost(is_mem, `CLK_3, `CLK_7);
				end
				`SUB_SUB: begin
					op_d  = `OP_SUB;
					clk_d = cost(is_mem, `CLK_3, `CLK_7);
				end
				`SUB_SUB_BORROW: begin
					op_d  = `OP_SUB_BORROW;
					clk_d = cost(is_mem, `CLK_3, `CLK_7);
				end
				`SUB_COMPARE: begin
					op_d  = `OP_COMPARE;
					clk_d = cost(is_mem, `CLK_3, `CLK_6);
				end
				default: known_d = 1'b0;
			endcase
		end else if (opcode[7:1] == `PAT_INCDEC_HI) begin
			modrm_d = 1'b1;
			case (sub)
				`SUB_INC: begin
					op_d  = `OP_INC;
					clk_d = cost(is_mem, `CLK_2, `CLK_7);
				end
				`SUB_DECR: begin
					op_d  = `OP_DECR;
					clk_d = cost(is_mem, `CLK_2, `CLK_7);
				end
				// other sub-fields belong to other slices
				default: known_d = 1'b0;
			endcase
		end else if (opcode[7:1] == `PAT_NEG_HI && sub == `SUB_NEG) begin
			op_d    = `OP_NEG;
			modrm_d = 1'b1;
			clk_d   = cost(is_mem, `CLK_2, `CLK_7);
		end else if (opcode[7:3] == `PAT_INC_REG_HI) begin
			op_d   = `OP_INC;
			clk_d  = `CLK_2;
			word_d = 1'b1;
			dest_d = 1'b1;
			reg_d  = opcode[2:0];
		end else if (opcode[7:3] == `PAT_DEC_REG_HI) begin
			op_d   = `OP_DECR;
			clk_d  = `CLK_2;
			word_d = 1'b1;
			dest_d = 1'b1;
			reg_d  = opcode[2:0];
		end else begin
			known_d = 1'b0;
		end
		// unknown opcodes clear op, clocks and flags; word bit, reg and r/m numbers still pass through
		if (!known_d) begin
			op_d    = `OP_NONE;
			clk_d   = 4'h0;
			modrm_d = 1'b0;
			dest_d  = 1'b0;
			sext_d  = 1'b0;
			acc_d   = 1'b0;
			imm_d   = 2'h0;
		end
	end

	// ****************************************
	// result register, one cycle after the byte
	// ****************************************
	always @(posedge clk) begin
		if (rst) begin
			dec_valid_q   <= 1'b0;
			dec_known_q   <= 1'b0;
			op_code_q     <= `OP_NONE;
			clocks_q      <= 4'h0;
			has_modrm_q   <= 1'b0;
			mem_operand_q <= 1'b0;
			word_op_q     <= 1'b0;
			reg_is_dest_q <= 1'b0;
			sign_extend_q <= 1'b0;
			acc_imm_q     <= 1'b0;
			imm_bytes_q   <= 2'h0;
			reg_num_q     <= 3'h0;
			rm_num_q      <= 3'h0;
		end else begin
			dec_valid_q <= instr_valid;
			// hold last result between valid bytes so the datapath sees it stable
			if (instr_valid) begin
				dec_known_q   <= known_d;
				op_code_q     <= op_d;
				clocks_q      <= clk_d;
				has_modrm_q   <= modrm_d;
				mem_operand_q <= modrm_d & is_mem;
				word_op_q     <= word_d;
				reg_is_dest_q <= dest_d;
				sign_extend_q <= sext_d;
				acc_imm_q     <= acc_d;
				imm_bytes_q   <= imm_d;
				reg_num_q     <= reg_d;
				rm_num_q      <= modrm[2:0];
			end
		end
	end

endmodule

/* flag_arith_consts.vh */
`ifndef FLAG_ARITH_CONSTS_VH
`define FLAG_ARITH_CONSTS_VH

// ****************************************
// operation codes reported on op_code
// ****************************************
`define OP_NONE        5'h00
`define OP_FLAGS_TO_HA 5'h01
`define OP_HA_TO_FLAGS 5'h02
`define OP_ADD         5'h03
`define OP_ADC         5'h04
`define OP_INC         5'h05
`define OP_SUB         5'h06
`define OP_SUB_BORROW  5'h07
`define OP_DECR        5'h08
`define OP_COMPARE     5'h09
`define OP_NEG         5'h0a
`define OP_AAA         5'h0b

// ****************************************
// opcode patterns
// ****************************************
`define PAT_FLAGS_TO_HA 8'h9f
`define PAT_HA_TO_FLAGS 8'h9e
`define PAT_AAA         8'h37
`define PAT_GRP1_HI     6'h20
`define PAT_INCDEC_HI   7'h7f
`define PAT_NEG_HI      7'h7b
`define PAT_INC_REG_HI  5'h08
`define PAT_DEC_REG_HI  5'h09
`define PAT_COMPARE_RM_HI  7'h1d
`define PAT_COMPARE_REG_HI 7'h1c

// ****************************************
// sub-field values of the mod/reg/r-m byte
// ****************************************
`define SUB_ADD 3'h0
`define SUB_ADC 3'h2
`define SUB_SUB_BORROW 3'h3
`define SUB_SUB        3'h5
`define SUB_COMPARE    3'h7
`define SUB_INC        3'h0
`define SUB_DECR       3'h1
`define SUB_NEG 3'h3
`define MOD_REG 2'h3

// ****************************************
// clock counts
// ****************************************
`define CLK_2 4'h2
`define CLK_3 4'h3
`define CLK_6 4'h6
`define CLK_7 4'h7

`endif

/* flag_arith_checker_assertions.sv */
`timescale 1ns/1ps
module flag_arith_checker (
	// clock and reset
	input wire       clk,
	input wire       rst,
	// request
	input wire       instr_valid,
	input wire [7:0] opcode,
	input wire [7:0] modrm,
	// result
	input wire       dec_valid_q,
	input wire [4:0] op_code_q,
	input wire [3:0] clocks_q,
	input wire       mem_operand_q,
	input wire       acc_imm_q,
	input wire [1:0] imm_bytes_q,
	input wire [2:0] reg_num_q
);
	// ****************
	// assertions
	// ****************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_flags_copy;
		instr_valid && opcode == 8'h9f |=> dec_valid_q && op_code_q == 5'h01 && clocks_q == 4'h2;
	endproperty
	a_flags_copy: assert property (p_flags_copy) else $error("flags copy");
	property p_flags_store;
		instr_valid && opcode == 8'h9e |=> op_code_q == 5'h02 && clocks_q == 4'h2;
	endproperty
	a_flags_store: assert property (p_flags_store) else $error("flags store");
	property p_ascii;
		instr_valid && opcode == 8'h37 |=> op_code_q == 5'h0b && clocks_q == 4'h3;
	endproperty
	a_ascii: assert property (p_ascii) else $error("ascii adjust");
	property p_add_mem;
		instr_valid && opcode[7:2] == 6'h00 && modrm[7:6] != 2'h3
			|=> op_code_q == 5'h03 && clocks_q == 4'h7 && mem_operand_q;
	endproperty
	a_add_mem: assert property (p_add_mem) else $error("add memory");
	property p_imm;
		instr_valid && opcode[7:2] == 6'h20
			|=> imm_bytes_q == ($past(opcode[1:0]) == 2'h1 ? 2'h2 : 2'h1);
	endproperty
	a_imm: assert property (p_imm) else $error("immediate count");
	property p_cmp_imm;
		instr_valid && opcode[7:2] == 6'h20 && modrm[5:3] == 3'h7 |=> op_code_q == 5'h09
			&& clocks_q == ($past(modrm[7:6]) == 2'h3 ? 4'h3 : 4'h6);
	endproperty
	a_cmp_imm: assert property (p_cmp_imm) else $error("compare immediate");
	property p_acc;
		instr_valid && opcode[7:1] == 7'h02 |=> acc_imm_q && clocks_q == 4'h3;
	endproperty
	a_acc: assert property (p_acc) else $error("acc immediate");
	property p_inc;
		instr_valid && opcode[7:3] == 5'h08
			|=> op_code_q == 5'h05 && reg_num_q == $past(opcode[2:0]);
	endproperty
	a_inc: assert property (p_inc) else $error("increment reg");
endmodule

bind flag_arith_decoder flag_arith_checker i_flag_arith_checker (
	.clk(clk), .rst(rst), .instr_valid(instr_valid), .opcode(opcode), .modrm(modrm),
	.dec_valid_q(dec_valid_q), .op_code_q(op_code_q), .clocks_q(clocks_q),
	.mem_operand_q(mem_operand_q), .acc_imm_q(acc_imm_q), .imm_bytes_q(imm_bytes_q),
	.reg_num_q(reg_num_q)
);

/* exec_sink.sv */
`timescale 1ns/1ps
module exec_sink (
	// clock and reset
	input  wire       clk,
	input  wire       rst,
	// decode result
	input  wire       dec_valid_q,
	input  wire [4:0] op_code_q,
	// last accepted op
	output logic [4:0] last_op_q
);
	always @(posedge clk) begin
		if (rst)
			last_op_q <= 5'h00;
		else if (dec_valid_q)
			last_op_q <= op_code_q;
	end
endmodule

/* test_flag_and_arith_opcode_decoder.sv */
`timescale 1ns/1ps
module test_flag_and_arith_opcode_decoder;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       instr_valid = 1'b0;
	logic [7:0] opcode = 8'h00;
	logic [7:0] modrm = 8'h00;
	wire        dec_valid_q, dec_known_q, has_modrm_q, mem_operand_q, word_op_q;
	wire        reg_is_dest_q, sign_extend_q, acc_imm_q;
	wire  [4:0] op_code_q, last_op_q;
	wire  [3:0] clocks_q;
	wire  [1:0] imm_bytes_q;
	wire  [2:0] reg_num_q, rm_num_q;
	int         error_cnt = 0;
	int         samples_checked = 0;

	flag_arith_decoder i_flag_arith_decoder (.clk(clk), .rst(rst), .instr_valid(instr_valid),
		.opcode(opcode), .modrm(modrm), .dec_valid_q(dec_valid_q), .dec_known_q(dec_known_q),
		.op_code_q(op_code_q), .clocks_q(clocks_q), .has_modrm_q(has_modrm_q),
		.mem_operand_q(mem_operand_q), .word_op_q(word_op_q), .reg_is_dest_q(reg_is_dest_q),
		.sign_extend_q(sign_extend_q), .acc_imm_q(acc_imm_q), .imm_bytes_q(imm_bytes_q),
		.reg_num_q(reg_num_q), .rm_num_q(rm_num_q));
	exec_sink i_exec_sink (.clk(clk), .rst(rst), .dec_valid_q(dec_valid_q),
		.op_code_q(op_code_q), .last_op_q(last_op_q));

	// ****************
	// helpers
	// ****************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one byte taken, result settled after the answering edge
	task automatic send(input logic [7:0] o, input logic [7:0] m);
		@(posedge clk);
		instr_valid <= 1'b1;
		opcode <= o;
		modrm <= m;
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
	endtask
	task automatic end_sim;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic t_b2b;
		@(posedge clk);
		instr_valid <= 1'b1;
		opcode <= 8'h9f;
		@(posedge clk);
		opcode <= 8'h37;
		#1;
		chk(op_code_q, 8'h01);
		@(posedge clk);
		opcode <= 8'h9e;
		#1;
		chk(clocks_q, 8'h03);
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
		chk(op_code_q, 8'h02);
		@(posedge clk);
		#1;
		chk({dec_valid_q, op_code_q, clocks_q[1:0]}, 8'h0a);
		chk(last_op_q, 8'h02);
	endtask
	task automatic t_regmem;
		logic [7:0] b [6] = '{8'h00, 8'h10, 8'h28, 8'h18, 8'h3a, 8'h38};
		logic [7:0] e [6] = '{8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h09};
		logic [7:0] m [6] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'h06, 8'h07};
		for (int i = 0; i < 12; i++) begin
			send(b[i/2] | {6'h00, i < 8 && i[0], i[0]}, i[0] ? 8'h4a : 8'hc1);
			chk(op_code_q, e[i/2]);
			chk(clocks_q, i[0] ? m[i/2] : 8'h02);
			chk({mem_operand_q, word_op_q, reg_num_q}, i[0] ? 8'h19 : 8'h00);
			chk({has_modrm_q, rm_num_q}, i[0] ? 8'h0a : 8'h09);
			chk(reg_is_dest_q, (i < 8 && i[0]) || i / 2 == 4);
		end
	endtask
	task automatic t_grp1;
		logic [2:0] s [5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h7};
		logic [7:0] e [5] = '{8'h03, 8'h04, 8'h07, 8'h06, 8'h09};
		for (int i = 0; i < 20; i++) begin
			send(8'h80 | 8'(i % 4), {i[0] ? 2'h2 : 2'h3, s[i/4], 3'h4});
			chk(op_code_q, e[i/4]);
			chk(clocks_q, i[0] ? (i / 4 == 4 ? 8'h06 : 8'h07) : 8'h03);
			chk({sign_extend_q, imm_bytes_q}, {i[1], i % 4 == 1 ? 2'h2 : 2'h1});
		end
	endtask
	task automatic t_acc;
		logic [7:0] b [5] = '{8'h04, 8'h14, 8'h2c, 8'h1c, 8'h3c};
		logic [7:0] e [5] = '{8'h03, 8'h04, 8'h06, 8'h07, 8'h09};
		for (int i = 0; i < 10; i++) begin
			send(b[i/2] | {7'h00, i[0]}, 8'hff);
			chk(op_code_q, e[i/2]);
			chk({acc_imm_q, imm_bytes_q, clocks_q}, {3'h5 + i[0], 4'h3});
		end
	endtask
	task automatic t_unary;
		logic [7:0] o [5] = '{8'hfe, 8'hff, 8'hf6, 8'hf7, 8'hf7};
		logic [7:0] m [5] = '{8'h06, 8'hc8, 8'hd8, 8'h5a, 8'hd0};
		logic [7:0] e [5] = '{8'h57, 8'h82, 8'ha2, 8'ha7, 8'h00};
		for (int i = 0; i < 5; i++) begin
			send(o[i], m[i]);
			chk({op_code_q[3:0], clocks_q}, e[i]);
			chk(dec_known_q, i < 4);
		end
		for (int r = 0; r < 16; r++) begin
			send(8'h40 + 8'(r), 8'h00);
			chk({op_code_q[3:0], 1'b0, reg_num_q}, {r < 8 ? 4'h5 : 4'h8, 4'(r % 8)});
		end
	endtask

	initial forever #2 clk = ~clk;
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_b2b;
		t_regmem;
		t_grp1;
		t_acc;
		t_unary;
		end_sim;
	end
	// far beyond the ~140 cycles the scenarios need
	initial begin
		#20000;
		error_cnt++;
		end_sim;
	end
endmodule
